//--- verilog/eio_regs.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * eight-bit io port. assumes an apb slave with 32-bit aligned words.
 */
`ifndef EIO_REGS_VH
`define EIO_REGS_VH

// register byte offsets
`define EIO_OFF_DATA      12'h000
`define EIO_OFF_DIR       12'h004
`define EIO_OFF_PULL      12'h010
`define EIO_OFF_SLOW      12'h014
`define EIO_OFF_IRQ_STAT  12'h018
`define EIO_OFF_IRQ_MASK  12'h01C

// reset values
`define EIO_DIR_RST       8'h00
`define EIO_PULL_RST      8'h00
`define EIO_SLOW_RST      1'b0
`define EIO_IRQ_RST       2'h0

// field positions
`define EIO_SLOW_BIT      0
`define EIO_IRQ_LOW_BIT   0
`define EIO_IRQ_SEVEN_BIT 1

// value returned for the write-only pull-control location
`define EIO_PULL_RD_VAL   32'h0000_0000

// slowed falling edge: time in ns and cycles at 40 MHz (rounded down, >= 1)
`define EIO_SLOW_NS       50
`define EIO_CLK_MHZ       40
`define EIO_SLOW_CYC      ((`EIO_SLOW_NS * `EIO_CLK_MHZ) / 1000)

`endif

//--- verilog/eio_line.v
/*
 * one port line: output value, open-drain handling, pull devices and the
 * slowed falling edge. assumes pin_in is synchronous to pclk.
 */
module eio_line #(
    parameter OPEN_DRAIN = 0,
    parameter SLOW_CYC   = 2
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       data_bit,
    input  wire       dir_bit,
    input  wire       pull_off,
    input  wire       pull_fitted,
    input  wire       pull_is_up,
    input  wire       slow_en,
    output reg        pin_out_ff,
    output reg        pin_oe_n_ff,
    output reg        pull_up_ff,
    output reg        pull_down_ff
);

    reg  [7:0] slow_cnt_ff;
    reg  [7:0] nxt_slow_cnt;
    reg        lvl_ff;
    wire       pull_on;
    wire       want;
    wire       drive;

    // pull device enabled only when fitted and its control bit is zero
    assign pull_on = pull_fitted & ~pull_off;
    assign want    = data_bit;
    // open-drain lines only ever drive low, never high
    assign drive   = dir_bit & (OPEN_DRAIN ? ~lvl_ff : 1'b1);

    // falling edges held high for slow_cyc cycles when slow enable is set
    always @* begin
        nxt_slow_cnt = 8'h00;
        if (dir_bit && slow_en && lvl_ff && !want &&
            slow_cnt_ff < SLOW_CYC[7:0]) begin
            nxt_slow_cnt = slow_cnt_ff + 8'h01;
        end
    end

    // output level tracks the data bit, delayed on slowed falls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt_ff  <= 8'h00;
            lvl_ff       <= 1'b1;
            pin_out_ff   <= 1'b0;
            pin_oe_n_ff  <= 1'b1;
            pull_up_ff   <= 1'b0;
            pull_down_ff <= 1'b0;
        end else begin
            slow_cnt_ff <= nxt_slow_cnt;
            if (!(dir_bit && slow_en && lvl_ff && !want &&
                  slow_cnt_ff < SLOW_CYC[7:0])) begin
                lvl_ff <= want;                        // see [RULE10]
            end
            pin_out_ff   <= OPEN_DRAIN ? 1'b0 : lvl_ff; // see [RULE12]
            pin_oe_n_ff  <= ~drive;                     // see [RULE3]
            // pullup acts always, pulldown only on inputs
            pull_up_ff   <= pull_on & pull_is_up;       // see [RULE9]
            pull_down_ff <= pull_on & ~pull_is_up & ~dir_bit;
        end
    end

endmodule // eio_line

//--- verilog/eio_port.v
/*
 * eight-bit general-purpose io port with apb register access, pull devices,
 * slowed falling edges and pin interrupts.
 * assumes pins are synchronous to pclk and a single apb master.
 */
// Chosen here: the APB slave port.
`include "eio_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// [RULE1] eight bidirectional lines each backed by a bit of the data register at 0x0.
// [RULE2] a direction bit of one makes its line an output, zero an input (0x4).
// [RULE3] an output line drives its pin to the stored data bit.
// [RULE4] reading data returns the pin level for lines set as input.
// [RULE5] reset leaves the data register contents unchanged.
// [RULE6] reset clears direction and pull-control, so lines start as inputs with pulls on.
// [RULE7] pull-control at 0x10 is write-only and reads back an undefined value.
// [RULE8] with pulls fitted, a pull acts while its control bit is zero.
// [RULE9] a pulldown acts only on inputs, a pullup regardless of direction.
// [RULE10] slow enable set slows falling edges of lines six and seven when outputs.
// [RULE11] slow enable resets to zero.
// [RULE12] lines six and seven are open-drain and only pull low.
// [RULE13] five pins feed the interrupt request, lines zero to three among them.
// [RULE14] lines zero to three raise on a high level or rising edge, one high masks the others.
// [RULE15] line seven raises only on a falling edge, gated by its own enable.
// [RULE16] the direction register reads back what was last written.
module eio_port #(
    parameter PULL_FITTED = 1,
    parameter PULL_IS_UP  = 8'hFF,
    parameter LOW_IRQ_OPT = 1,
    parameter LOW_LEVEL   = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  pin_in,
    output wire [7:0]  pin_out,
    output wire [7:0]  pin_oe_n,
    output wire [7:0]  pull_up,
    output wire [7:0]  pull_down,
    output reg         slow_fall_enable,
    output reg         irq
);

    reg  [7:0]  port_data_ff;
    reg  [7:0]  port_direction_ff;
    reg  [7:0]  port_pull_control_ff;
    reg         slow_ff;
    reg  [1:0]  irq_stat_ff;
    reg  [1:0]  irq_mask_ff;
    reg  [3:0]  low_prev_ff;
    reg         seven_prev_ff;
    reg         low_any_prev_ff;
    reg  [1:0]  nxt_irq_stat;
    reg  [31:0] nxt_prdata;
    reg         nxt_slverr;
    wire        wr_acc;
    wire        rd_acc;
    wire        setup;
    wire [7:0]  rd_data;
    wire        low_any;
    wire        low_evt;
    wire        seven_evt;
    genvar      g;

    //////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, pready raised in the access phase
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = setup & ~pwrite;

    // input lines read the pin, output lines the stored bit
    assign rd_data = (port_direction_ff & port_data_ff) |
                     (~port_direction_ff & pin_in);     // see [RULE4]

    // read mux evaluated in setup so prdata is a flop in the access phase
    always @* begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (paddr == `EIO_OFF_DATA) begin
            nxt_prdata = {24'h00_0000, rd_data};
        end else if (paddr == `EIO_OFF_DIR) begin
            nxt_prdata = {24'h00_0000, port_direction_ff}; // see [RULE16]
        end else if (paddr == `EIO_OFF_PULL) begin
            nxt_prdata = `EIO_PULL_RD_VAL;              // see [RULE7]
        end else if (paddr == `EIO_OFF_SLOW) begin
            nxt_prdata = {31'h0000_0000, slow_ff};
        end else if (paddr == `EIO_OFF_IRQ_STAT) begin
            nxt_prdata = {30'h0000_0000, irq_stat_ff};
        end else if (paddr == `EIO_OFF_IRQ_MASK) begin
            nxt_prdata = {30'h0000_0000, irq_mask_ff};
        end else begin
            nxt_slverr = 1'b1;                          // unmapped address
        end
    end

    // bus handshake flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & nxt_slverr;
            if (rd_acc) begin
                prdata <= nxt_prdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // data register has no reset: contents survive reset
    always @(posedge pclk) begin
        if (wr_acc && paddr == `EIO_OFF_DATA) begin
            port_data_ff <= pwdata[7:0];                // see [RULE1] [RULE5]
        end
    end

    // control registers cleared by reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction_ff    <= `EIO_DIR_RST;       // see [RULE6]
            port_pull_control_ff <= `EIO_PULL_RST;
            slow_ff              <= `EIO_SLOW_RST;      // see [RULE11]
            irq_mask_ff          <= `EIO_IRQ_RST;
            slow_fall_enable     <= `EIO_SLOW_RST;
        end else begin
            if (wr_acc && paddr == `EIO_OFF_DIR) begin
                port_direction_ff <= pwdata[7:0];       // see [RULE2]
            end
            if (wr_acc && paddr == `EIO_OFF_PULL) begin
                port_pull_control_ff <= pwdata[7:0];    // see [RULE8]
            end
            if (wr_acc && paddr == `EIO_OFF_SLOW) begin
                slow_ff <= pwdata[`EIO_SLOW_BIT];
            end
            if (wr_acc && paddr == `EIO_OFF_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
            // shared with the second port's lines outside this block
            slow_fall_enable <= slow_ff;                // see [RULE10]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin interrupts: lines zero to three act like the irq pin inverted
    assign low_any   = |(pin_in[3:0] & ~port_direction_ff[3:0]);
    // a rising edge counts only while no other low line is high already
    assign low_evt   = LOW_IRQ_OPT &&
                       ((LOW_LEVEL && low_any) ||
                        (|(pin_in[3:0] & ~low_prev_ff) && !low_any_prev_ff));
    assign seven_evt = seven_prev_ff & ~pin_in[7];      // see [RULE15]

    // sticky status, set wins over a write-one clear
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_acc && paddr == `EIO_OFF_IRQ_STAT) begin
            nxt_irq_stat = irq_stat_ff & ~pwdata[1:0];
        end
        if (low_evt) begin
            nxt_irq_stat[`EIO_IRQ_LOW_BIT] = 1'b1;      // see [RULE14]
        end
        if (seven_evt) begin
            nxt_irq_stat[`EIO_IRQ_SEVEN_BIT] = 1'b1;
        end
    end

    // edge history and interrupt output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff     <= `EIO_IRQ_RST;
            low_prev_ff     <= 4'h0;
            low_any_prev_ff <= 1'b0;
            seven_prev_ff   <= 1'b0;
            irq             <= 1'b0;
        end else begin
            irq_stat_ff     <= nxt_irq_stat;
            low_prev_ff     <= pin_in[3:0];
            low_any_prev_ff <= low_any;
            seven_prev_ff   <= pin_in[7];
            irq             <= |(nxt_irq_stat & irq_mask_ff); // see [RULE13]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // one line slice per pin; six and seven are open-drain with slow falls
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_line
            eio_line #(
                .OPEN_DRAIN (g >= 6),
                .SLOW_CYC   (`EIO_SLOW_CYC)
            ) u_line (
                .pclk         (pclk),
                .presetn      (presetn),
                .data_bit     (port_data_ff[g]),
                .dir_bit      (port_direction_ff[g]),
                .pull_off     (port_pull_control_ff[g]),
                .pull_fitted  (PULL_FITTED != 0),
                .pull_is_up   (PULL_IS_UP[g]),
                .slow_en      (slow_ff & (g >= 6)),     // see [RULE10]
                .pin_out_ff   (pin_out[g]),
                .pin_oe_n_ff  (pin_oe_n[g]),
                .pull_up_ff   (pull_up[g]),
                .pull_down_ff (pull_down[g])
            );
        end
    endgenerate

endmodule // eio_port

//--- verif/eio_port_monitor.sv
/* concurrent checks on the eio_port pins and apb answer.
   assumes it is bound to every eio_port and sees only its ports. */
module eio_port_mon #(
    parameter PULL_IS_UP = 8'hFF
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [7:0]  pin_out,
    input logic [7:0]  pin_oe_n,
    input logic [7:0]  pull_up,
    input logic [7:0]  pull_down,
    input logic        slow_fall_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;
    logic       wr;
    logic [7:0] dir_w;
    // completed transfer, qualified the way the master samples it
    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;
    // last direction word written; lags the write edge by design
    always_ff @(posedge pclk) begin
        if (wr && paddr == 12'h004) dir_w <= pwdata[7:0];
    end
    ////////////////////////////////////////////////////////////////////////
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_UNMAPPED: assert property (acc && !(paddr inside {12'h000,
        12'h004, 12'h010, 12'h014, 12'h018, 12'h01C}) |-> pslverr)
        else $error("unmapped access not refused");
    AST_OPEN_DRAIN: assert property (pin_out[7:6] == 2'b00)
        else $error("open drain line driven high");
    AST_PDN_INPUT: assert property ((pull_down[5:0] & ~pin_oe_n[5:0])
        == 6'h00) else $error("pulldown on an output");
    AST_PULL_KIND: assert property (((pull_up & ~PULL_IS_UP)
        | (pull_down & PULL_IS_UP)) == 8'h00) else $error("wrong pull kind");
    AST_RESET: assert property ($rose(presetn) |-> pin_oe_n == 8'hFF
        && !slow_fall_enable) else $error("bad state after reset");
    AST_PULL_RD: assert property (acc && !pwrite && paddr == 12'h010
        |-> prdata == 32'h0000_0000) else $error("pull read not zero");
    AST_DIR_OE: assert property (wr && paddr == 12'h004 |=>
        ##[0:3] pin_oe_n[5:0] == ~dir_w[5:0]) else $error("dir not applied");
endmodule // eio_port_mon

bind eio_port eio_port_mon #(.PULL_IS_UP(PULL_IS_UP)) i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up(pull_up), .pull_down(pull_down),
    .slow_fall_enable(slow_fall_enable));

//--- verif/eio_pins.sv
/* board model of the eight port pins: external drivers, pulls, float.
   assumes the bench never drives a pin the port drives. */
module eio_pins (
    input  logic       pclk,
    input  logic [7:0] pin_out,
    input  logic [7:0] pin_oe_n,
    input  logic [7:0] pull_up,
    input  logic [7:0] pull_down,
    input  logic [7:0] ext_val,
    input  logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] flt_ff = 8'h55;
    // a floating pin wanders so a stale level never looks valid
    always_ff @(posedge pclk) flt_ff <= ~flt_ff;
    // port drive first, then board driver, then pulls, else float
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & (pull_up | (~pull_down & flt_ff)));
endmodule // eio_pins

//--- verif/testbench.sv
/* self-checking bench for eio_port over apb with a pin model.
   assumes eio_regs.vh offsets and the bound eio_port_mon. */
`include "eio_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic        slow_fall_enable, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pull_up, pull_down;
    logic [7:0]  ext_val, ext_en;
    int          fail_count = 0;
    int          checks_done = 0;
    // ordinary register cases: address, write, read back, refused
    logic [11:0] t_a [5] = '{`EIO_OFF_DIR, `EIO_OFF_SLOW,
        `EIO_OFF_IRQ_MASK, `EIO_OFF_PULL, 12'h020};
    logic [31:0] t_w [5] = '{32'hA5, 32'h1, 32'h3, 32'hFF, 32'h5A};
    logic [31:0] t_r [5] = '{32'hA5, 32'h1, 32'h3, 32'h0, 32'h0};
    logic        t_e [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    always #12.5 pclk = ~pclk;
    eio_port #(.PULL_IS_UP(8'h0F)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pull_up(pull_up), .pull_down(pull_down),
        .slow_fall_enable(slow_fall_enable), .irq(irq));
    eio_pins i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_up(pull_up), .pull_down(pull_down), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask
    // one apb transfer; a spare idle edge keeps drivers single per step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_val = 8'h00;
        ext_en = 8'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk(pin_oe_n, 8'hFF, "oe");
        chk(pull_up, 8'h0F, "pu");
        chk(pull_down, 8'hF0, "pd");
        apb(1'b0, `EIO_OFF_SLOW, 32'h0);
        chk(rdat, 32'h0, "slow");
        $display("done: reset");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, t_a[i], t_w[i]);
            apb(1'b0, t_a[i], 32'h0);
            chk(rdat, t_r[i], "reg");
            chk(rerr, t_e[i], "err");
        end
        chk(slow_fall_enable, 1'b1, "slow out");
        $display("done: registers");
        apb(1'b1, `EIO_OFF_DIR, 32'hFF);
        apb(1'b1, `EIO_OFF_DATA, 32'h3C);
        settle();
        chk({pin_out, pin_oe_n}, 16'h3C00, "drive");
        chk({pull_up, pull_down}, 16'h0000, "pulls");
        apb(1'b1, `EIO_OFF_DATA, 32'hC3);
        settle();
        chk({pin_out, pin_oe_n}, 16'h03C0, "od");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `EIO_OFF_DIR, 32'hFF);
        apb(1'b0, `EIO_OFF_DATA, 32'h0);
        chk(rdat, 32'hC3, "kept");
        $display("done: outputs");
        apb(1'b1, `EIO_OFF_DIR, 32'h0);
        ext_en <= 8'hFF;
        ext_val <= 8'h96;
        settle();
        apb(1'b0, `EIO_OFF_DATA, 32'h0);
        chk(rdat, 32'h96, "pins");
        apb(1'b1, `EIO_OFF_PULL, 32'hFF);
        settle();
        chk({pull_up, pull_down}, 16'h0000, "off");
        ext_val <= 8'h00;
        settle();
        apb(1'b1, `EIO_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `EIO_OFF_IRQ_MASK, 32'h0);
        ext_val <= 8'h81;
        settle();
        apb(1'b0, `EIO_OFF_IRQ_STAT, 32'h0);
        chk({rdat[30:0], irq}, 32'h2, "lvl");
        apb(1'b1, `EIO_OFF_IRQ_MASK, 32'h1);
        settle();
        chk(irq, 1'b1, "irq");
        ext_val <= 8'h00;
        settle();
        apb(1'b1, `EIO_OFF_IRQ_STAT, 32'h1);
        apb(1'b0, `EIO_OFF_IRQ_STAT, 32'h0);
        chk({rdat[30:0], irq}, 32'h4, "fall");
        $display("done: interrupts");
        print_verdict();
    end
endmodule // testbench
